// ---- rtl/adc_capture_pkg.sv ----
package adc_capture_pkg;
   // Register offsets on the plain register port
   localparam logic [3:0] RESULT_LOW_OFFSET = 4'h0;
   localparam logic [3:0] PREVIOUS_HIGH_OFFSET = 4'h1;
   localparam logic [3:0] PREVIOUS_LOW_OFFSET = 4'h2;
   localparam logic [3:0] CONTROL_OFFSET = 4'h3;
   // Control register fields
   localparam int JUSTIFY_BIT = 0;
   localparam int SOURCE_BIT = 1;
   // Control value after reset: left justified, previous result as source
   localparam logic [1:0] CONTROL_RESET = 2'h0;
   // Read data value after reset and on unmapped reads
   localparam logic [7:0] READ_IDLE = 8'h00;
   // Conversion result width and padding for justification
   localparam int RESULT_WIDTH = 10;
   localparam int PAD_WIDTH = 16 - RESULT_WIDTH;
endpackage : adc_capture_pkg

// ---- rtl/previous_capture_if.sv ----
`timescale 1ns/1ps
interface previous_capture_if;
   logic capture_start; // One-cycle conversion start event
   logic previous_source_select; // 1 picks the filter output
   logic result_justify_select; // 1 right, 0 left justified
   logic [9:0] conversion_result; // Result held from the last conversion
   logic [15:0] filter_output_value; // Filter accumulator output
   logic [15:0] previous_result_value; // Captured previous value
   modport ctrl (
      output capture_start,
      output previous_source_select,
      output result_justify_select,
      output conversion_result,
      output filter_output_value,
      input previous_result_value
   );
   modport capt (
      input capture_start,
      input previous_source_select,
      input result_justify_select,
      input conversion_result,
      input filter_output_value,
      output previous_result_value
   );
endinterface : previous_capture_if

// ---- rtl/previous_capture.sv ----
`timescale 1ns/1ps
module previous_capture
   import adc_capture_pkg::*;
(
   input wire logic core_clk,
   previous_capture_if.capt cap
);
   // Captured value; no reset, it powers up unknown
   logic [15:0] previous_reg;
   logic [15:0] previous_next;
   // Conversion result placed by the justify select
   logic [15:0] justified_result;

   // Right puts the result in the low bits, left in the high bits
   assign justified_result = cap.result_justify_select ?
      {{PAD_WIDTH{1'b0}}, cap.conversion_result} :
      {cap.conversion_result, {PAD_WIDTH{1'b0}}};
   // Source choice: full 16-bit filter output or justified prior result
   assign previous_next = cap.previous_source_select ?
      cap.filter_output_value : justified_result;

   // Sampled on the start edge, before result or filter move on
   always_ff @(posedge core_clk) begin
      if (cap.capture_start) begin
         previous_reg <= previous_next;
      end
   end

   assign cap.previous_result_value = previous_reg;
endmodule : previous_capture

// ---- rtl/adc_result_previous_capture.sv ----
// Notes on behaviour
// - Right justified: low byte gets result bits 7:0
// - Low byte read/write, unknown at power-up, kept
// - Filter source: previous high gets filter upper byte
// - Result source: previous high gets prior result bits
// - Result source: previous bytes follow justify select
// - Previous high byte read-only, unknown at power-up
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module adc_result_previous_capture
   import adc_capture_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rd_data,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [9:0] conv_result,
   input wire logic [15:0] filter_output_value
);
   // Carrier to the capture module
   previous_capture_if cap_if ();

   // Control register: justify and source select
   logic [1:0] control_reg;
   logic [1:0] control_next;
   // Low result byte; no reset so other resets leave it alone
   logic [7:0] result_low_reg;
   logic [7:0] result_low_next;
   // Full 10-bit result kept for the previous capture
   logic [9:0] result_hold_reg;
   // Read data register, valid in the cycle after the strobe
   logic [7:0] read_data_reg;
   logic [7:0] read_data_next;

   // Address decode
   wire wr_low = reg_wr && (reg_addr == RESULT_LOW_OFFSET);
   wire wr_control = reg_wr && (reg_addr == CONTROL_OFFSET);
   wire justify_right = control_reg[JUSTIFY_BIT];
   wire source_filter = control_reg[SOURCE_BIT];
   // Low byte from a finished conversion in the chosen format
   wire [7:0] done_low_byte = justify_right ? conv_result[7:0] :
      {conv_result[1:0], {PAD_WIDTH{1'b0}}};

   // Conversion completion wins over a software write in the same cycle
   assign result_low_next = conv_done ? done_low_byte :
      wr_low ? reg_wr_data : result_low_reg;
   assign control_next = wr_control ? reg_wr_data[1:0] : control_reg;

   // Read mux; unmapped addresses and the gap above read as zero
   always_comb begin
      read_data_next = READ_IDLE;
      if (reg_rd) begin
         case (reg_addr)
            RESULT_LOW_OFFSET: read_data_next = result_low_reg;
            PREVIOUS_HIGH_OFFSET: read_data_next = cap_if.previous_result_value[15:8];
            PREVIOUS_LOW_OFFSET: read_data_next = cap_if.previous_result_value[7:0];
            CONTROL_OFFSET: read_data_next = {6'h00, control_reg};
            default: read_data_next = READ_IDLE;
         endcase
      end
   end

   // Control and read data have a defined reset value
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         control_reg <= CONTROL_RESET;
         read_data_reg <= READ_IDLE;
      end else begin
         control_reg <= control_next;
         read_data_reg <= read_data_next;
      end
   end

   // Result storage has no reset: unknown at power-up, kept otherwise
   always_ff @(posedge core_clk) begin
      result_low_reg <= result_low_next;
      if (conv_done) begin
         result_hold_reg <= conv_result;
      end
   end

   // Capture sees the held result before this cycle's update lands
   assign cap_if.capture_start = conv_start;
   assign cap_if.previous_source_select = source_filter;
   assign cap_if.result_justify_select = justify_right;
   assign cap_if.conversion_result = result_hold_reg;
   assign cap_if.filter_output_value = filter_output_value;

   // Previous-result capture
   previous_capture u_capture (
      .core_clk(core_clk),
      .cap(cap_if.capt)
   );

   assign reg_rd_data = read_data_reg;

   // Right justified completion loads the low result bits
   a_low_byte_right: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      conv_done && justify_right |=> result_low_reg == $past(conv_result[7:0]))
      else $error("low byte missed right justified result");

   // Software write lands when no conversion completes
   a_low_byte_write: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      wr_low && !conv_done |=> result_low_reg == $past(reg_wr_data))
      else $error("low byte write lost");

   // Low byte holds without a write or a completion
   a_low_byte_hold: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !wr_low && !conv_done |=> $stable(result_low_reg))
      else $error("low byte changed unprompted");

   // Filter source loads the filter value at the start
   a_prev_from_filter: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      conv_start && source_filter
      |=> cap_if.previous_result_value[15:8] == $past(filter_output_value[15:8]))
      else $error("previous high not from filter");

   // Result source, right justified
   a_prev_result_right: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      conv_start && !source_filter && justify_right
      |=> cap_if.previous_result_value == {6'h00, $past(result_hold_reg)})
      else $error("previous value not right justified result");

   // Result source, left justified
   a_prev_result_left: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      conv_start && !source_filter && !justify_right
      |=> cap_if.previous_result_value == {$past(result_hold_reg), 6'h00})
      else $error("previous value not left justified result");

   // Writes to the previous high byte change nothing
   a_prev_read_only: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_wr && reg_addr == PREVIOUS_HIGH_OFFSET && !conv_start
      |=> $stable(cap_if.previous_result_value))
      else $error("previous value changed by write");

   // Read of the previous high byte returns bits 15:8
   a_prev_high_read: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == PREVIOUS_HIGH_OFFSET && !conv_start
      |=> reg_rd_data == cap_if.previous_result_value[15:8])
      else $error("previous high read wrong");

   // Start and completion together: capture takes the old result
   a_capture_first: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      conv_start && conv_done && !source_filter && justify_right
      |=> cap_if.previous_result_value[9:0] == $past(result_hold_reg)
          && result_hold_reg == $past(conv_result))
      else $error("capture took the new result");

   // Left justified completion puts result bits 1:0 on top of the low byte
   a_low_byte_left: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      conv_done && !justify_right |=> result_low_reg == {$past(conv_result[1:0]), 6'h00})
      else $error("low byte missed left justified result");

   // Completion beats a software write in the same cycle
   a_done_beats_write: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      wr_low && conv_done && justify_right
      |=> result_low_reg == $past(conv_result[7:0]))
      else $error("low byte write beat completion");

   // Read of the low byte returns the stored value
   a_low_byte_read: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == RESULT_LOW_OFFSET |=> reg_rd_data == $past(result_low_reg))
      else $error("low byte read wrong");

   // Read of the previous low byte returns bits 7:0
   a_prev_low_read: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == PREVIOUS_LOW_OFFSET
      |=> reg_rd_data == $past(cap_if.previous_result_value[7:0]))
      else $error("previous low read wrong");

   // Read data stands one cycle only, zero between reads
   a_read_idle: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !reg_rd |=> reg_rd_data == READ_IDLE)
      else $error("read data not idle");

   // Addresses above the control register read as zero
   a_unmapped_read: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr > CONTROL_OFFSET |=> reg_rd_data == READ_IDLE)
      else $error("unmapped read not zero");

   // Filter source also fills the lower byte of the previous value
   a_prev_low_filter: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      conv_start && source_filter
      |=> cap_if.previous_result_value[7:0] == $past(filter_output_value[7:0]))
      else $error("previous low not from filter");

   // Held result follows every completion, ready for the next start
   a_held_result_load: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      conv_done |=> result_hold_reg == $past(conv_result))
      else $error("held result not loaded");

   // Control write sets justify and source selects
   a_control_write: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      wr_control |=> control_reg == $past(reg_wr_data[1:0]))
      else $error("control write lost");

   // Control read returns both select bits
   a_control_read: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == CONTROL_OFFSET |=> reg_rd_data == {6'h00, $past(control_reg)})
      else $error("control read wrong");
endmodule : adc_result_previous_capture

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
   import adc_capture_pkg::*;
   logic core_clk; // 10 MHz bench clock
   logic rst_n; // Async reset, active low
   logic [3:0] reg_addr;
   logic [7:0] reg_wr_data;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rd_data;
   logic conv_start;
   logic conv_done;
   logic [9:0] conv_result;
   logic [15:0] filter_output_value;
   logic [7:0] exp_q[$]; // Expected read data, oldest first
   logic rd_seen; // Read strobe taken last edge
   logic [9:0] held; // Model of the held result
   logic [15:0] prev; // Model of the previous value
   logic [7:0] low; // Model of the low byte
   logic [1:0] ctrl; // Model of the control bits
   integer seed = 29;
   int miscompares = 0;
   int check_count = 0;

   adc_result_previous_capture u_adc_result_previous_capture (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rd_data(reg_rd_data), .conv_start(conv_start), .conv_done(conv_done),
      .conv_result(conv_result), .filter_output_value(filter_output_value));

   // Free-running clock, 100 ns period
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Single compare point for every result
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expd);
      check_count++;
      if (seen !== expd) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, expd, seen);
      end
   endtask : check

   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // One-cycle register read, expectation noted first
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask : rd

   // Conversion events; model takes previous before the new result lands
   task automatic conv(input logic dn, input logic st, input logic [9:0] r, input logic [15:0] f);
      @(posedge core_clk);
      conv_done <= dn;
      conv_start <= st;
      conv_result <= r;
      filter_output_value <= f;
      if (st) prev = ctrl[SOURCE_BIT] ? f : ctrl[JUSTIFY_BIT] ? {6'h00, held} : {held, 6'h00};
      if (dn) begin
         held = r;
         low = ctrl[JUSTIFY_BIT] ? r[7:0] : {r[1:0], 6'h00};
      end
      @(posedge core_clk);
      conv_done <= 1'b0;
      conv_start <= 1'b0;
      // Scramble sources so stale sampling shows up
      conv_result <= 10'($random(seed));
      filter_output_value <= 16'($random(seed));
   endtask : conv

   // Read back all three result bytes
   task automatic check_all();
      rd(RESULT_LOW_OFFSET, low);
      rd(PREVIOUS_HIGH_OFFSET, prev[15:8]);
      rd(PREVIOUS_LOW_OFFSET, prev[7:0]);
   endtask : check_all

   // Note which edges carry read data
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) rd_seen <= 1'b0;
      else rd_seen <= reg_rd;
   end

   // Mid-cycle monitor: data in the cycle after a read, idle otherwise
   always @(negedge core_clk) begin
      if (rd_seen) check("read data", reg_rd_data, exp_q.pop_front());
      else if (rst_n) check("idle read data", reg_rd_data, READ_IDLE);
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   // Watchdog at 3000 cycles, far beyond the roughly 140 cycles needed
   initial begin
      #(3000 * 100);
      miscompares++;
      print_verdict();
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      reg_addr = 4'h0;
      reg_wr_data = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      conv_start = 1'b0;
      conv_done = 1'b0;
      conv_result = 10'h000;
      filter_output_value = 16'h0000;
      ctrl = CONTROL_RESET;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int a = 4; a < 16; a++) rd(4'(a), READ_IDLE);
      $display("test unmapped done");
      low = 8'($random(seed));
      wr(RESULT_LOW_OFFSET, low);
      rd(RESULT_LOW_OFFSET, low);
      $display("test low byte access done");
      // Every justify and source combination
      for (int m = 0; m < 4; m++) begin
         ctrl = 2'(m);
         wr(CONTROL_OFFSET, {6'h00, ctrl});
         rd(CONTROL_OFFSET, {6'h00, ctrl});
         conv(1'b1, 1'b0, (m == 1) ? 10'h3FF : 10'($random(seed)), 16'h0000);
         conv(1'b0, 1'b1, 10'h000, 16'($random(seed)));
         check_all();
      end
      $display("test modes done");
      // Start and done together: previous takes the old result
      ctrl = 2'h1;
      wr(CONTROL_OFFSET, {6'h00, ctrl});
      conv(1'b1, 1'b1, 10'($random(seed)), 16'($random(seed)));
      // Completion and low byte write on one edge: completion wins
      fork
         wr(RESULT_LOW_OFFSET, ~low);
         conv(1'b1, 1'b0, 10'($random(seed)), 16'h0000);
      join
      check_all();
      $display("test same cycle done");
      // Read-only bytes ignore writes
      wr(PREVIOUS_HIGH_OFFSET, ~prev[15:8]);
      wr(PREVIOUS_LOW_OFFSET, ~prev[7:0]);
      check_all();
      $display("test read only done");
      // Second reset keeps stored bytes, control goes back to left/result
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      ctrl = CONTROL_RESET;
      rd(CONTROL_OFFSET, {6'h00, ctrl});
      rd(RESULT_LOW_OFFSET, low);
      conv(1'b0, 1'b1, 10'h000, 16'($random(seed)));
      check_all();
      $display("test second reset done");
      repeat (3) @(posedge core_clk);
      print_verdict();
   end
endmodule : tb
